// ### dll_dqs_pkg.sv
// Constants, register map and field layout of the strobe delay control block
package dll_dqs_pkg;
    // APB register byte offsets
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] WLEVEL_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    // Control register field positions
    localparam int CTRL_TIME_REF  = 0;
    localparam int CTRL_GEARBOX   = 1;
    localparam int CTRL_SHIFT_LSB = 2;
    localparam int CTRL_DIV2      = 5;
    localparam int CTRL_DIV4      = 6;
    localparam int CTRL_WIDTH     = 7;
    // Status register field positions
    localparam int STAT_LOCK      = 0;
    localparam int STAT_MISMATCH  = 1;
    localparam int STAT_DIR       = 2;
    localparam int STAT_CODE_LSB  = 8;
    localparam int STAT_CAL_LSB   = 16;
    // Reset values and delay code limit
    localparam logic [6:0] CTRL_RESET   = 7'h00;
    localparam logic [7:0] WLEVEL_RESET = 8'h00;
    localparam logic [6:0] CODE_RESET   = 7'h00;
    localparam logic [6:0] CODE_MAX     = 7'h7F;
    // Widths and depths
    localparam int CODE_W    = 7;
    localparam int GRAY_W    = 6;
    localparam int WL_W      = 8;
    localparam int SHIFT_W   = 3;
    localparam int HIST_D    = 128;
    localparam int SYNC_W    = 13;
    // Lock qualification: aligned reference edges in a row
    localparam logic [2:0] LOCK_COUNT = 3'h4;
    // Synchroniser bundle bit positions
    localparam int P_REF   = 0;
    localparam int P_FB    = 1;
    localparam int P_DLL_RESET_N  = 2;
    localparam int P_FRZ   = 3;
    localparam int P_UPD   = 4;
    localparam int P_DIR   = 5;
    localparam int P_DQS   = 6;
    localparam int P_GRAY  = 7;
endpackage

// ### dll_dqs_delay_control.sv
// Delay-locked loop control, read strobe delay and write strobe generation
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/10ps
module dll_dqs_delay_control (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        ref_clk_in,
    input  wire logic        feedback_clk_in,
    input  wire logic        dll_reset_n,
    input  wire logic        delay_code_freeze,
    input  wire logic        code_update_strobe,
    input  wire logic        step_dir_in,
    input  wire logic [5:0]  gray_code_in,
    input  wire logic        dqs_in,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             primary_clk_out,
    output logic             secondary_clk_out,
    output logic             lock,
    output logic             step_dir_out,
    output logic      [5:0]  gray_code_out,
    output logic             code_mismatch_flag,
    output logic      [6:0]  delay_cal_code,
    output logic             read_strobe_delayed,
    output logic             capture_clk_polarity,
    output logic             gearbox_transfer_strobe,
    output logic             write_gear_clk0,
    output logic             write_gear_clk1,
    output logic             write_strobe_out
);
    // Gray to binary, used for the peer bus
    function automatic logic [5:0] gray2bin(input logic [5:0] g);
        logic [5:0] b;
        b[5] = g[5];
        for (int i = 4; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // Binary to gray, used for the own bus
    function automatic logic [5:0] bin2gray(input logic [5:0] b);
        return b ^ (b >> 1);
    endfunction

    logic [dll_dqs_pkg::SYNC_W-1:0]  sync1_reg;      // First stage, read by second only
    logic [dll_dqs_pkg::SYNC_W-1:0]  sync2_reg;      // Second stage
    logic [dll_dqs_pkg::SYNC_W-1:0]  sync3_reg;      // Third stage
    logic [dll_dqs_pkg::SYNC_W-1:0]  pin_reg;        // Settled pin levels
    logic [dll_dqs_pkg::SYNC_W-1:0]  pin_prev_reg;   // Settled levels one cycle back
    logic [dll_dqs_pkg::CTRL_WIDTH-1:0] ctrl_reg;    // Control register
    logic [dll_dqs_pkg::WL_W-1:0]    wlevel_reg;     // Write leveling delay
    logic [dll_dqs_pkg::CODE_W-1:0]  code_reg;       // Internal delay setting
    logic [dll_dqs_pkg::CODE_W-1:0]  cal_reg;        // Presented calibration code
    logic [2:0]                      align_cnt_reg;  // Aligned edges in a row
    logic                            lock_reg;       // Phase lock
    logic                            dir_reg;        // Last step direction
    logic [dll_dqs_pkg::HIST_D-1:0]  clk_hist_reg;   // Primary clock history
    logic [dll_dqs_pkg::HIST_D-1:0]  dqs_hist_reg;   // Strobe history
    logic                            div2_reg;       // Shifted clock divided by 2
    logic                            div4_reg;       // Shifted clock divided by 4
    logic                            shifted_prev_reg; // Edge detect of shifted clock
    logic                            div2_prev_reg;  // Edge detect of div2
    logic                            rstrobe_prev_reg; // Edge detect of delayed strobe
    logic                            pair_reg;       // Odd/even strobe edge
    logic                            sec_reg;        // Secondary clock output
    logic                            rsd_reg;        // Delayed read strobe
    logic                            pol_reg;        // Capture polarity
    logic                            xfer_reg;       // Gearbox transfer pulse
    logic                            wg0_reg;        // Write gearing clock 0
    logic                            wg1_reg;        // Write gearing clock 1
    logic                            wstr_reg;       // Write strobe
    logic [31:0]                     prdata_reg;     // Read data
    logic                            pslverr_reg;    // Error response

    logic dll_rst;       // Loop reset, bus reset or DLL pin low
    logic ref_rise;      // Settled reference rising edge
    logic fb_rise;       // Settled feedback rising edge
    logic update_take;   // Two-cycle update strobe seen
    logic time_ref;      // Follow peer code
    logic shifted_clk;   // Primary clock after fine shift
    logic rstrobe_next;  // Delayed strobe before register
    logic [5:0] peer_bin;  // Peer code in binary
    logic apb_access;    // Access phase
    logic addr_ok;       // Mapped offset

    assign dll_rst     = sys_rst | ~pin_reg[dll_dqs_pkg::P_DLL_RESET_N];
    assign ref_rise    = pin_reg[dll_dqs_pkg::P_REF] & ~pin_prev_reg[dll_dqs_pkg::P_REF];
    assign fb_rise     = pin_reg[dll_dqs_pkg::P_FB] & ~pin_prev_reg[dll_dqs_pkg::P_FB];
    // Two consecutive high samples, relies on the peer holding it that long
    assign update_take = pin_reg[dll_dqs_pkg::P_UPD] & pin_prev_reg[dll_dqs_pkg::P_UPD];
    assign time_ref    = ctrl_reg[dll_dqs_pkg::CTRL_TIME_REF];
    assign peer_bin    = gray2bin(pin_reg[dll_dqs_pkg::P_GRAY +: dll_dqs_pkg::GRAY_W]);
    assign shifted_clk = clk_hist_reg[ctrl_reg[dll_dqs_pkg::CTRL_SHIFT_LSB +: dll_dqs_pkg::SHIFT_W]];
    // Quarter period: a quarter of the calibrated delay in clock cycles
    assign rstrobe_next = dqs_hist_reg[{2'h0, cal_reg[6:2]}];
    assign apb_access  = psel & penable;
    assign addr_ok     = (paddr == dll_dqs_pkg::CTRL_OFFSET) | (paddr == dll_dqs_pkg::WLEVEL_OFFSET)
                       | (paddr == dll_dqs_pkg::STATUS_OFFSET);

    // Pin synchroniser; a change counts once stages two and three agree
    always_ff @(posedge mclk) begin
        sync1_reg <= {gray_code_in, dqs_in, step_dir_in, code_update_strobe, delay_code_freeze,
                      dll_reset_n, feedback_clk_in, ref_clk_in};
        sync2_reg <= sync1_reg;
        sync3_reg <= sync2_reg;
        if (sys_rst) begin
            pin_reg      <= '0;
            pin_prev_reg <= '0;
        end else begin
            pin_reg      <= ((sync2_reg ~^ sync3_reg) & sync3_reg) | ((sync2_reg ^ sync3_reg) & pin_reg);
            pin_prev_reg <= pin_reg;
        end
    end

    // APB register writes; zero wait states
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_reg   <= dll_dqs_pkg::CTRL_RESET;
            wlevel_reg <= dll_dqs_pkg::WLEVEL_RESET;
        end else if (apb_access & pwrite) begin
            if (paddr == dll_dqs_pkg::CTRL_OFFSET) begin
                ctrl_reg <= pwdata[dll_dqs_pkg::CTRL_WIDTH-1:0];
            end
            // Controller picks the leveling step here
            if (paddr == dll_dqs_pkg::WLEVEL_OFFSET) begin
                wlevel_reg <= pwdata[dll_dqs_pkg::WL_W-1:0];
            end
        end
    end

    // APB read data and error answer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prdata_reg  <= '0;
            pslverr_reg <= 1'b0;
        end else if (psel & ~penable) begin
            pslverr_reg <= ~addr_ok;
            prdata_reg  <= '0;
            if (~pwrite) begin
                unique case (paddr)
                    dll_dqs_pkg::CTRL_OFFSET: begin
                        prdata_reg <= {25'h0000000, ctrl_reg};
                    end
                    dll_dqs_pkg::WLEVEL_OFFSET: begin
                        prdata_reg <= {24'h000000, wlevel_reg};
                    end
                    dll_dqs_pkg::STATUS_OFFSET: begin
                        prdata_reg <= {9'h000, cal_reg, 1'b0, code_reg, 5'h00, dir_reg,
                                       code_mismatch_flag, lock_reg};
                    end
                    default: begin
                        prdata_reg <= '0;
                    end
                endcase
            end
        end
    end

    // Delay code loop: step toward alignment, or follow the peer
    always_ff @(posedge mclk) begin
        if (dll_rst) begin
            code_reg <= dll_dqs_pkg::CODE_RESET;
            dir_reg  <= 1'b0;
        end else if (time_ref) begin
            // Peer code and its direction taken together
            code_reg <= {peer_bin, 1'b0};
            dir_reg  <= pin_reg[dll_dqs_pkg::P_DIR];
        end else if (pin_reg[dll_dqs_pkg::P_FRZ]) begin
            // Arithmetic stopped; code holds
            code_reg <= code_reg;
        end else if (ref_rise & ~fb_rise) begin
            // Feedback already high means it leads: shorten; else lengthen
            if (pin_reg[dll_dqs_pkg::P_FB] & (code_reg != dll_dqs_pkg::CODE_RESET)) begin
                code_reg <= code_reg - 7'h01;
                dir_reg  <= 1'b0;
            end else if (~pin_reg[dll_dqs_pkg::P_FB] & (code_reg != dll_dqs_pkg::CODE_MAX)) begin
                code_reg <= code_reg + 7'h01;
                dir_reg  <= 1'b1;
            end
        end
    end

    // Lock qualifier; any misaligned reference edge drops lock
    always_ff @(posedge mclk) begin
        if (dll_rst) begin
            align_cnt_reg <= '0;
            lock_reg      <= 1'b0;
        end else if (ref_rise) begin
            if (fb_rise) begin
                if (align_cnt_reg != dll_dqs_pkg::LOCK_COUNT) begin
                    align_cnt_reg <= align_cnt_reg + 3'h1;
                end
                lock_reg <= (align_cnt_reg + 3'h1) >= dll_dqs_pkg::LOCK_COUNT;
            end else begin
                align_cnt_reg <= '0;
                lock_reg      <= 1'b0;
            end
        end
    end

    // Calibration code moves to the strobe blocks only on a qualified update
    always_ff @(posedge mclk) begin
        if (dll_rst) begin
            cal_reg <= dll_dqs_pkg::CODE_RESET;
        end else if (update_take) begin
            cal_reg <= code_reg;
        end
    end

    // Clock and strobe histories; tap k lags the settled pin level by k+1 cycles
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            clk_hist_reg <= '0;
            dqs_hist_reg <= '0;
        end else begin
            clk_hist_reg <= {clk_hist_reg[dll_dqs_pkg::HIST_D-2:0], pin_reg[dll_dqs_pkg::P_REF]};
            dqs_hist_reg <= {dqs_hist_reg[dll_dqs_pkg::HIST_D-2:0], pin_reg[dll_dqs_pkg::P_DQS]};
        end
    end

    // Secondary clock: shifted, then optional divide; divide by 4 wins over 2
    always_ff @(posedge mclk) begin
        if (dll_rst) begin
            div2_reg         <= 1'b0;
            div4_reg         <= 1'b0;
            shifted_prev_reg <= 1'b0;
            div2_prev_reg    <= 1'b0;
            sec_reg          <= 1'b0;
        end else begin
            shifted_prev_reg <= shifted_clk;
            div2_prev_reg    <= div2_reg;
            if (shifted_clk & ~shifted_prev_reg) begin
                div2_reg <= ~div2_reg;
            end
            if (div2_reg & ~div2_prev_reg) begin
                div4_reg <= ~div4_reg;
            end
            if (ctrl_reg[dll_dqs_pkg::CTRL_DIV4]) begin
                sec_reg <= div4_reg;
            end else if (ctrl_reg[dll_dqs_pkg::CTRL_DIV2]) begin
                sec_reg <= div2_reg;
            end else begin
                sec_reg <= shifted_clk;
            end
        end
    end

    // Read side: delayed strobe, polarity and gearbox transfer
    always_ff @(posedge mclk) begin
        if (dll_rst) begin
            rsd_reg          <= 1'b0;
            rstrobe_prev_reg <= 1'b0;
            pol_reg          <= 1'b0;
            pair_reg         <= 1'b0;
            xfer_reg         <= 1'b0;
        end else begin
            rsd_reg          <= rstrobe_next;
            rstrobe_prev_reg <= rsd_reg;
            xfer_reg         <= 1'b0;
            if (rsd_reg & ~rstrobe_prev_reg) begin
                // Primary clock level at the strobe edge picks the capture edge
                pol_reg  <= pin_reg[dll_dqs_pkg::P_REF];
                pair_reg <= ~pair_reg;
                // One pulse per pair of strobe edges in gearbox mode
                xfer_reg <= ctrl_reg[dll_dqs_pkg::CTRL_GEARBOX] & pair_reg;
            end
        end
    end

    // Write side: gearing clocks and leveled write strobe
    always_ff @(posedge mclk) begin
        if (dll_rst) begin
            wg0_reg  <= 1'b0;
            wg1_reg  <= 1'b0;
            wstr_reg <= 1'b0;
        end else begin
            wg0_reg  <= pin_reg[dll_dqs_pkg::P_REF];
            wg1_reg  <= div2_reg;
            // Leveling tap on top of the calibrated delay, top bit inverts
            wstr_reg <= clk_hist_reg[cal_reg + wlevel_reg[6:0]] ^ wlevel_reg[dll_dqs_pkg::WL_W-1];
        end
    end

    // Output drive; gray bus carries code bits 6 to 1, so a loop step moves it by at most one bit
    assign gray_code_out        = bin2gray(code_reg[6:1]);
    assign delay_cal_code       = cal_reg;
    assign code_mismatch_flag   = cal_reg != code_reg;
    assign lock                 = lock_reg;
    assign step_dir_out         = dir_reg;
    assign primary_clk_out      = wg0_reg;
    assign secondary_clk_out    = sec_reg;
    assign read_strobe_delayed  = rsd_reg;
    assign capture_clk_polarity = pol_reg;
    assign gearbox_transfer_strobe = xfer_reg;
    assign write_gear_clk0      = wg0_reg;
    assign write_gear_clk1      = wg1_reg;
    assign write_strobe_out     = wstr_reg;
    assign prdata               = prdata_reg;
    assign pslverr              = pslverr_reg & apb_access;
    assign pready               = 1'b1;

    // Assertions
    a_freeze_holds_code: assert property (@(posedge mclk) disable iff (dll_rst)
        (pin_reg[dll_dqs_pkg::P_FRZ] & ~time_ref) |=> $stable(code_reg))
        else $error("code moved while frozen");
    a_update_loads_cal: assert property (@(posedge mclk) disable iff (dll_rst)
        update_take |=> (cal_reg == $past(code_reg)))
        else $error("update did not load calibration code");
    a_cal_held_idle: assert property (@(posedge mclk) disable iff (dll_rst)
        (~update_take) |=> $stable(cal_reg))
        else $error("calibration code moved without update");
    a_lock_needs_align: assert property (@(posedge mclk) disable iff (dll_rst)
        (ref_rise & ~fb_rise) |=> ~lock)
        else $error("lock kept after misaligned edge");
    // Right after an update the flag may only stay up if the loop stepped again
    a_mismatch_flag: assert property (@(posedge mclk) disable iff (dll_rst)
        update_take |=> (~code_mismatch_flag | $changed(code_reg)))
        else $error("mismatch flag wrong");
    a_gray_one_bit: assert property (@(posedge mclk) disable iff (dll_rst)
        $countones(gray_code_out ^ $past(gray_code_out)) <= 1)
        else $error("gray bus changed more than one bit");
    a_step_direction: assert property (@(posedge mclk) disable iff (dll_rst)
        (~time_ref & (code_reg > $past(code_reg))) |-> step_dir_out)
        else $error("direction missing on increment");
    a_time_ref_follow: assert property (@(posedge mclk) disable iff (dll_rst)
        (time_ref & $past(time_ref)) |-> (code_reg[6:1] == $past(peer_bin)))
        else $error("time reference code not followed");
    a_xfer_gearbox: assert property (@(posedge mclk) disable iff (dll_rst)
        gearbox_transfer_strobe |-> ($past(ctrl_reg[dll_dqs_pkg::CTRL_GEARBOX]) ##1 ~gearbox_transfer_strobe))
        else $error("transfer pulse outside gearbox mode");
    // The cycle after loop reset still shows the reset value, not the tap
    a_wstrobe_invert: assert property (@(posedge mclk) disable iff (dll_rst)
        (~$past(dll_rst)) |->
        (write_strobe_out == ($past(clk_hist_reg[cal_reg + wlevel_reg[6:0]]) ^ $past(wlevel_reg[7]))))
        else $error("write strobe tap or inversion wrong");
    c_lock_reached: cover property (@(posedge mclk) disable iff (dll_rst) $rose(lock));
    c_cal_update: cover property (@(posedge mclk) disable iff (dll_rst) update_take ##1 ~code_mismatch_flag);
    c_gearbox_xfer: cover property (@(posedge mclk) disable iff (dll_rst) gearbox_transfer_strobe);
    c_time_ref: cover property (@(posedge mclk) disable iff (dll_rst) time_ref ##2 $changed(code_reg));
endmodule

// ### dll_far_side.sv
// Far-side model: reference clock, feedback path and memory strobe
`timescale 1ns/10ps
module dll_far_side (
    input  wire logic       mclk,
    input  wire logic       ref_run,
    input  wire logic [1:0] fb_mode,
    input  wire logic       dqs_run,
    output logic            ref_clk_in,
    output logic            feedback_clk_in,
    output logic            dqs_in
);
    logic [6:0] div_reg = 7'h00; // Shared divider for clock and strobe
    logic [1:0] lag_reg = 2'h0;  // Feedback delay line
    // Reference stands still low outside runs; period is 8 mclk
    always_ff @(posedge mclk) begin
        div_reg <= div_reg + 7'h01;
        ref_clk_in <= ref_run & div_reg[2];
        lag_reg <= {lag_reg[0], ref_clk_in};
    end
    // Feedback: 0 aligned copy, 1 held low, else two cycles late
    always_comb begin
        case (fb_mode)
            2'h0: feedback_clk_in = ref_clk_in;
            2'h1: feedback_clk_in = 1'b0;
            default: feedback_clk_in = lag_reg[1];
        endcase
    end
    // Strobe is not free running: low between bursts, period 128 mclk
    always_ff @(posedge mclk) begin
        dqs_in <= dqs_run & div_reg[6];
    end
endmodule

// ### dll_dqs_delay_control_test.sv
// Self-checking bench for the strobe delay control block
`timescale 1ns/10ps
module dll_dqs_delay_control_test;
    typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} row_t;
    localparam logic [7:0] ST = dll_dqs_pkg::STATUS_OFFSET;
    logic        mclk, sys_rst, dll_reset_n, delay_code_freeze, code_update_strobe, step_dir_in;
    logic        psel, penable, pwrite, ref_run, dqs_run, gray_watch, err, ref_clk_in, feedback_clk_in;
    logic        dqs_in, pready, pslverr, primary_clk_out, secondary_clk_out, lock, step_dir_out;
    logic        code_mismatch_flag, read_strobe_delayed, capture_clk_polarity, gearbox_transfer_strobe;
    logic        write_gear_clk0, write_gear_clk1, write_strobe_out;
    logic [1:0]  fb_mode;
    logic [5:0]  gray_code_in, gray_code_out, gray_prev;
    logic [6:0]  delay_cal_code;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    int          err_count, checks, i, p, s, r, g, q, w;
    // Register rows: offset, write value, read-back value, error
    row_t        rows [5] = '{'{8'h00, 32'hFFFFFFFF, 32'h7F, 1'b0}, '{8'h04, 32'h1A5, 32'hA5, 1'b0},
                              '{8'h08, 32'hFFFFFFFF, 32'h0, 1'b0}, '{8'h0C, 32'h12345678, 32'h0, 1'b1},
                              '{8'h00, 32'h0, 32'h0, 1'b0}};
    dll_dqs_delay_control dut_u (.mclk, .sys_rst, .ref_clk_in, .feedback_clk_in, .dll_reset_n,
        .delay_code_freeze, .code_update_strobe, .step_dir_in, .gray_code_in, .dqs_in(dqs_in), .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .primary_clk_out,
        .secondary_clk_out, .lock, .step_dir_out, .gray_code_out, .code_mismatch_flag, .delay_cal_code,
        .read_strobe_delayed, .capture_clk_polarity, .gearbox_transfer_strobe, .write_gear_clk0,
        .write_gear_clk1, .write_strobe_out);
    dll_far_side far_u (.mclk, .ref_run, .fb_mode, .dqs_run, .ref_clk_in, .feedback_clk_in, .dqs_in);
    always #2 mclk = ~mclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks=%0d errors=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // A wait that used up its bound ends the run
    task automatic bound(input int k, input int lim);
        if (k >= lim) begin
            err_count++;
            test_done();
        end
    endtask
    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int t;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge mclk);
            t++;
        end while (pready !== 1'b1 && t < 16);
        bound(t, 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    // Counts rises of the clock outputs and the delayed strobe, and transfer pulses
    task automatic count_edges(input int k);
        logic [4:0] pv;
        {p, s, r, g, q, w} = 0;
        pv = {write_gear_clk0, write_gear_clk1, read_strobe_delayed, secondary_clk_out, primary_clk_out};
        repeat (k) begin
            @(posedge mclk);
            p += primary_clk_out & ~pv[0];
            s += secondary_clk_out & ~pv[1];
            r += read_strobe_delayed & ~pv[2];
            q += write_gear_clk1 & ~pv[3];
            w += write_gear_clk0 & ~pv[4];
            g += gearbox_transfer_strobe;
            pv = {write_gear_clk0, write_gear_clk1, read_strobe_delayed, secondary_clk_out, primary_clk_out};
        end
    endtask
    // Gray bus may only move one bit per change while the loop steps
    always @(posedge mclk) begin
        if (gray_watch && gray_code_out !== gray_prev) check($countones(gray_code_out ^ gray_prev), 1);
        gray_prev <= gray_code_out;
    end
    // Watchdog far beyond the longest scenario
    initial begin
        #400000;
        err_count++;
        test_done();
    end
    initial begin
        {mclk, dll_reset_n, delay_code_freeze, code_update_strobe, step_dir_in, psel, penable} = 0;
        {pwrite, ref_run, dqs_run, gray_watch, gray_code_in, gray_prev, paddr, pwdata, fb_mode} = 0;
        {err_count, checks, rd} = 0;
        sys_rst = 1'b1;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        check({pready, lock, gray_code_out, delay_cal_code}, 32'h4000);
        // Table rows while the loop is still held in reset
        foreach (rows[k]) begin
            apb(1'b1, rows[k].a, rows[k].w);
            apb(1'b0, rows[k].a, 32'h0);
            check(rd, rows[k].r);
            check(err, rows[k].e);
        end
        // Frozen loop must not step although feedback stays low
        {delay_code_freeze, dll_reset_n, ref_run, fb_mode} <= 5'h1D;
        repeat (100) @(posedge mclk);
        apb(1'b0, ST, 32'h0);
        check(rd[14:8], 7'h00);
        delay_code_freeze <= 1'b0;
        gray_watch <= 1'b1;
        for (i = 0; i < 600 && rd[14:8] !== 7'h7F; i++) apb(1'b0, ST, 32'h0);
        bound(i, 600);
        check(rd, 32'h7F06);
        check(gray_code_out, 6'h20);
        gray_watch <= 1'b0;
        // A single-cycle update strobe is ignored, two cycles load the code
        code_update_strobe <= 1'b1;
        @(posedge mclk);
        code_update_strobe <= 1'b0;
        repeat (12) @(posedge mclk);
        check(delay_cal_code, 7'h00);
        code_update_strobe <= 1'b1;
        repeat (2) @(posedge mclk);
        code_update_strobe <= 1'b0;
        for (i = 0; i < 20 && delay_cal_code !== 7'h7F; i++) @(posedge mclk);
        check({code_mismatch_flag, delay_cal_code}, 8'h7F);
        // Lock follows alignment of the feedback edge
        fb_mode <= 2'h0;
        for (i = 0; i < 100 && lock !== 1'b1; i++) @(posedge mclk);
        check(lock, 1'b1);
        fb_mode <= 2'h2;
        for (i = 0; i < 40 && lock !== 1'b0; i++) @(posedge mclk);
        check(lock, 1'b0);
        // Strobe delay of a quarter of the code, transfer pulse every second rise
        apb(1'b1, 8'h00, 32'h02);
        dqs_run <= 1'b1;
        for (i = 0; i < 200 && dqs_in !== 1'b1; i++) @(posedge mclk);
        for (i = 0; i < 60 && read_strobe_delayed !== 1'b1; i++) @(posedge mclk);
        check(i >= 31 && i <= 38, 1'b1);
        count_edges(600);
        check(r >= 4 && (r / 2 == g || (r + 1) / 2 == g), 1'b1);
        // Strobe rise lands 33 cycles into a reference period of 8: reference is low there
        check(capture_clk_polarity, 1'b0);
        dqs_run <= 1'b0;
        // Secondary clock divided by 2, then by 4; gearing clock 0 follows the reference, clock 1 runs at half its rate
        for (i = 2; i <= 4; i += 2) begin
            apb(1'b1, 8'h00, i * 16);
            repeat (20) @(posedge mclk);
            count_edges(256);
            check(s >= p / i - 1 && s <= p / i + 1 && p >= 30, 1'b1);
            check(q >= p / 2 - 1 && q <= p / 2 + 1 && w == p, 1'b1);
        end
        // Time reference mode follows the peer code and direction
        apb(1'b1, 8'h00, 32'h01);
        // A real peer moves its gray bus one bit per step: 0x01, 0x05, then 0x15
        for (i = 0; i < 3; i++) begin
            gray_code_in <= gray_code_in | (6'h01 << (2 * i));
            repeat (8) @(posedge mclk);
        end
        for (i = 0; i < 20 && gray_code_out !== 6'h15; i++) @(posedge mclk);
        apb(1'b0, ST, 32'h0);
        check({rd[14:8], step_dir_out}, 8'h64);
        {step_dir_in, gray_code_in} <= 7'h54;
        for (i = 0; i < 20 && gray_code_out !== 6'h14; i++) @(posedge mclk);
        check({gray_code_out, step_dir_out}, 7'h29);
        // Idle reference: write strobe shows only the inversion bit
        apb(1'b1, 8'h00, 32'h0);
        ref_run <= 1'b0;
        apb(1'b1, 8'h04, 32'h80);
        repeat (140) @(posedge mclk);
        check(write_strobe_out, 1'b1);
        apb(1'b1, 8'h04, 32'h00);
        repeat (4) @(posedge mclk);
        check(write_strobe_out, 1'b0);
        // Loop reset in mid-run clears code and lock
        dll_reset_n <= 1'b0;
        repeat (8) @(posedge mclk);
        check({lock, delay_cal_code}, 8'h00);
        test_done();
    end
endmodule
